// ---- fcca_top.sv ----
// frame count with trailer append, Avalon-MM register slave and interrupt
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
module fcca_top
  import fcca_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // acquisition events, same clock domain, one-cycle pulses
  input wire logic frame_begin_event_i,
  input wire logic frame_trigger_i,
  // input lines from pins
  input wire logic input_line_one_i,
  input wire logic input_line_two_i,
  // image stream in
  input wire logic img_valid_i,
  input wire logic img_last_i,
  input wire logic [31:0] img_data_i,
  output logic img_ready_o,
  // image stream to host
  output logic out_valid_o,
  output logic out_last_o,
  output logic [31:0] out_data_o,
  input wire logic out_ready_i,
  // status
  output logic payload_with_trailer_o,
  output logic irq_o
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [2:0] {
    FCCA_ST_IMAGE = 3'b001,
    FCCA_ST_TRAIL = 3'b010,
    FCCA_ST_DONE = 3'b100
  } fcca_state_t;

  typedef struct packed {
    fcca_state_t state;
    logic mode_on;
    logic [1:0] item_sel;
    logic frame_item_en;
    logic [1:0] clr_src;
    logic [1:0] slot_sel;
    logic [1:0] evt_src;
    logic [31:0] fcount;
    logic [31:0] tcount;
    logic [31:0] captured;
    logic [31:0] trail_val;
    logic [FCCA_IRQ_W-1:0] stat;
    logic [FCCA_IRQ_W-1:0] mask;
    logic bus_ack;
    logic [31:0] rdata;
    fcca_beat_t out;
    logic irq;
  } fcca_st_t;

  fcca_st_t st_ff;
  fcca_st_t nxt_st;

  fcca_bus_req_t req;
  logic line_one_rise;
  logic line_two_rise;

  // byte-lane merge of write data
  function automatic logic [31:0] fcca_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ***************************************************************
  // input line synchronisers
  // ***************************************************************
  fcca_sync u_sync_l1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(input_line_one_i),
    .level_o(),
    .rise_o(line_one_rise)
  );

  fcca_sync u_sync_l2 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(input_line_two_i),
    .level_o(),
    .rise_o(line_two_rise)
  );

  assign req.address = avs_address_i;
  assign req.read = avs_read_i;
  assign req.write = avs_write_i;
  assign req.writedata = avs_writedata_i;
  assign req.byteenable = avs_byteenable_i;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic wr;
    logic [31:0] ctrl_rd;
    logic [31:0] clr_rd;
    logic [31:0] wv;
    logic soft_clr;
    logic line_clr;
    logic do_clr;
    logic out_take;
    logic in_take;
    logic [FCCA_IRQ_W-1:0] ev;
    wr = 1'b0;
    ctrl_rd = '0;
    clr_rd = '0;
    wv = '0;
    soft_clr = 1'b0;
    line_clr = 1'b0;
    do_clr = 1'b0;
    out_take = 1'b0;
    in_take = 1'b0;
    ev = '0;
    nxt_st = st_ff;

    ctrl_rd[FCCA_CTRL_MODE_BIT] = st_ff.mode_on;
    ctrl_rd[FCCA_CTRL_SEL_LSB +: 2] = st_ff.item_sel;
    ctrl_rd[FCCA_CTRL_EN_BIT] = (st_ff.item_sel == FCCA_ITEM_FRAME_NUM) & st_ff.frame_item_en;
    ctrl_rd[FCCA_CTRL_PAY_BIT] = st_ff.mode_on;
    ctrl_rd[FCCA_CTRL_FEN_BIT] = st_ff.frame_item_en;
    clr_rd[FCCA_CLR_SRC_LSB +: 2] = st_ff.clr_src;
    clr_rd[FCCA_CLR_SLOT_LSB +: 2] = st_ff.slot_sel;
    clr_rd[FCCA_CLR_EVT_LSB +: 2] = st_ff.evt_src;

    // bus: one wait cycle, then acknowledge
    nxt_st.bus_ack = (req.read | req.write) & ~st_ff.bus_ack;
    wr = req.write & ~st_ff.bus_ack;
    if (req.read & ~st_ff.bus_ack) begin
      unique case (req.address)
        FCCA_OFS_CTRL: nxt_st.rdata = ctrl_rd;
        FCCA_OFS_CLR: nxt_st.rdata = clr_rd;
        FCCA_OFS_FCOUNT: nxt_st.rdata = st_ff.fcount;
        FCCA_OFS_TCOUNT: nxt_st.rdata = st_ff.tcount;
        FCCA_OFS_STAT: nxt_st.rdata = 32'(st_ff.stat);
        FCCA_OFS_MASK: nxt_st.rdata = 32'(st_ff.mask);
        FCCA_OFS_LAST: nxt_st.rdata = st_ff.captured;
        default: nxt_st.rdata = FCCA_UNMAPPED;
      endcase
    end

    if (wr) begin
      unique case (req.address)
        FCCA_OFS_CTRL: begin
          wv = fcca_merge(ctrl_rd, req.writedata, req.byteenable);
          nxt_st.mode_on = wv[FCCA_CTRL_MODE_BIT];
          nxt_st.item_sel = wv[FCCA_CTRL_SEL_LSB +: 2];
          if (wv[FCCA_CTRL_SEL_LSB +: 2] == FCCA_ITEM_FRAME_NUM) begin
            nxt_st.frame_item_en = wv[FCCA_CTRL_EN_BIT];
          end
          if (!wv[FCCA_CTRL_MODE_BIT]) begin
            nxt_st.frame_item_en = 1'b0;
          end
        end
        FCCA_OFS_CLR: begin
          wv = fcca_merge(clr_rd, req.writedata, req.byteenable);
          nxt_st.clr_src = wv[FCCA_CLR_SRC_LSB +: 2];
          nxt_st.slot_sel = wv[FCCA_CLR_SLOT_LSB +: 2];
          nxt_st.evt_src = wv[FCCA_CLR_EVT_LSB +: 2];
          soft_clr = req.byteenable[2] & req.writedata[FCCA_CLR_CMD_BIT]
                     & (st_ff.clr_src == FCCA_SRC_SOFT);
        end
        FCCA_OFS_MASK: nxt_st.mask = req.writedata[FCCA_IRQ_W-1:0];
        default: ;
      endcase
    end

    line_clr = ((st_ff.clr_src == FCCA_SRC_LINE_ONE) & line_one_rise)
               | ((st_ff.clr_src == FCCA_SRC_LINE_TWO) & line_two_rise);
    do_clr = soft_clr | line_clr;

    if (frame_begin_event_i) begin
      ev[FCCA_IRQ_FRAME] = 1'b1;
      if (st_ff.fcount == FCCA_COUNT_MAX) begin
        ev[FCCA_IRQ_WRAP] = 1'b1;
      end
      nxt_st.fcount = 32'(st_ff.fcount + 32'h0000_0001);
      nxt_st.captured = st_ff.fcount;
    end
    // clear to zero, wins over count
    if (do_clr) begin
      nxt_st.fcount = FCCA_FCOUNT_RST;
      ev[FCCA_IRQ_CLEAR] = 1'b1;
    end

    if (frame_trigger_i) begin
      nxt_st.tcount = 32'(st_ff.tcount + 32'h0000_0001);
    end

    // ***** stream with trailer append *****
    out_take = st_ff.out.valid & out_ready_i;
    if (out_take) begin
      nxt_st.out.valid = 1'b0;
    end
    unique case (st_ff.state)
      FCCA_ST_IMAGE: begin
        in_take = img_valid_i & (~st_ff.out.valid | out_ready_i);
        if (in_take) begin
          nxt_st.out.valid = 1'b1;
          nxt_st.out.data = img_data_i;
          nxt_st.out.last = img_last_i & ~st_ff.frame_item_en;
          if (img_last_i) begin
            nxt_st.trail_val = st_ff.captured;
            nxt_st.state = st_ff.frame_item_en ? FCCA_ST_TRAIL : FCCA_ST_IMAGE;
          end
        end
      end
      FCCA_ST_TRAIL: begin
        if (~st_ff.out.valid | out_ready_i) begin
          nxt_st.out.valid = 1'b1;
          nxt_st.out.data = st_ff.trail_val;
          nxt_st.out.last = 1'b1;
          nxt_st.state = FCCA_ST_IMAGE;
        end
      end
      default: nxt_st.state = FCCA_ST_IMAGE;
    endcase

    // sticky status, set wins over clear
    if (wr && req.address == FCCA_OFS_STAT) begin
      nxt_st.stat = st_ff.stat & ~req.writedata[FCCA_IRQ_W-1:0];
    end
    nxt_st.stat = nxt_st.stat | ev;
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // reset clears count; source none
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.state <= FCCA_ST_IMAGE;
      st_ff.clr_src <= FCCA_SRC_NONE;
      st_ff.fcount <= FCCA_FCOUNT_RST;
      st_ff.tcount <= FCCA_TCOUNT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_ff.bus_ack;
  assign img_ready_o = (st_ff.state == FCCA_ST_IMAGE) & (~st_ff.out.valid | out_ready_i);
  assign out_valid_o = st_ff.out.valid;
  assign out_last_o = st_ff.out.last;
  assign out_data_o = st_ff.out.data;
  assign payload_with_trailer_o = st_ff.mode_on;
  assign irq_o = st_ff.irq;

endmodule // fcca_top

// ---- fcca_pkg.sv ----
// package: constants, register map and carrier types for the frame count trailer block
package fcca_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [3:0] FCCA_REG_CTRL = 4'h0;      // trailer mode, select, enable
  localparam logic [3:0] FCCA_REG_CLR = 4'h4;       // clear source, slot, event, command
  localparam logic [3:0] FCCA_REG_FCOUNT = 4'h8;    // live frame count (ro)
  localparam logic [3:0] FCCA_REG_TCOUNT = 4'hC;    // trigger input count (ro)

  localparam logic [5:0] FCCA_OFS_CTRL = 6'h00;
  localparam logic [5:0] FCCA_OFS_CLR = 6'h04;
  localparam logic [5:0] FCCA_OFS_FCOUNT = 6'h08;
  localparam logic [5:0] FCCA_OFS_TCOUNT = 6'h0C;
  localparam logic [5:0] FCCA_OFS_STAT = 6'h10;
  localparam logic [5:0] FCCA_OFS_MASK = 6'h14;
  localparam logic [5:0] FCCA_OFS_LAST = 6'h18;     // last captured frame count (ro)

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int FCCA_CTRL_MODE_BIT = 0;    // trailer_mode_on
  localparam int FCCA_CTRL_EN_BIT = 1;      // trailer_item_enable for selected item
  localparam int FCCA_CTRL_SEL_LSB = 4;     // trailer_item_select, 2 bits
  localparam int FCCA_CTRL_PAY_BIT = 8;     // payload_with_trailer (ro)
  localparam int FCCA_CTRL_FEN_BIT = 9;     // frame count item enabled (ro)
  localparam int FCCA_CLR_SRC_LSB = 0;      // count_clear_source, 2 bits
  localparam int FCCA_CLR_SLOT_LSB = 4;     // counter slot selector, 2 bits
  localparam int FCCA_CLR_EVT_LSB = 8;      // count_event_source, 2 bits
  localparam int FCCA_CLR_CMD_BIT = 16;     // count_clear_command, write-one pulse
  localparam int FCCA_IRQ_W = 3;
  localparam int FCCA_IRQ_FRAME = 0;        // frame counted
  localparam int FCCA_IRQ_CLEAR = 1;        // count cleared
  localparam int FCCA_IRQ_WRAP = 2;         // count rolled over

  // ***************************************************************
  // encodings and reset values
  // ***************************************************************
  localparam logic [1:0] FCCA_SRC_NONE = 2'h0;
  localparam logic [1:0] FCCA_SRC_LINE_ONE = 2'h1;
  localparam logic [1:0] FCCA_SRC_LINE_TWO = 2'h2;
  localparam logic [1:0] FCCA_SRC_SOFT = 2'h3;
  localparam logic [1:0] FCCA_ITEM_FRAME_NUM = 2'h1;
  localparam logic [1:0] FCCA_SLOT_SECOND = 2'h1;
  localparam logic [1:0] FCCA_EVT_FRAME_BEGIN = 2'h1;
  localparam logic [31:0] FCCA_FCOUNT_RST = 32'h0000_0000;
  localparam logic [31:0] FCCA_TCOUNT_RST = 32'h0000_0001;
  localparam logic [31:0] FCCA_COUNT_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] FCCA_UNMAPPED = 32'h0000_0000;

  // ***************************************************************
  // carrier types
  // ***************************************************************
  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fcca_bus_req_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } fcca_beat_t;

endpackage : fcca_pkg

// ---- fcca_sync.sv ----
// two-flop synchroniser plus rising edge pulse for a pin input
module fcca_sync
  import fcca_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // pin side
  input wire logic pin_i,
  // synchronised side
  output logic level_o,
  output logic rise_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } fcca_sync_st_t;

  fcca_sync_st_t st_ff;
  fcca_sync_st_t nxt_st;

  // first flop feeds only the second
  always_comb begin
    nxt_st.meta = pin_i;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.sync;
  assign rise_o = st_ff.sync & ~st_ff.prev;

endmodule // fcca_sync

// ---- fcca_props.sv ----
// checker: port assertions for the frame count trailer block
module fcca_props
  import fcca_pkg::*;
(
  // clock, reset and register bus
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // streams and status
  input wire logic img_valid_i,
  input wire logic img_last_i,
  input wire logic img_ready_o,
  input wire logic out_valid_o,
  input wire logic out_last_o,
  input wire logic [31:0] out_data_o,
  input wire logic out_ready_i,
  input wire logic payload_with_trailer_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  logic wr_ok;
  logic img_ok;
  // bus request, accepted bus writes and accepted image beats
  assign req = avs_read_i || avs_write_i;
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  assign img_ok = img_valid_i && img_ready_o;
  // bus handshake timing, unmapped reads and interrupt masking
  a_wait_one: assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
  a_ack_once: assert property (req && !avs_waitrequest_o |=> !req || avs_waitrequest_o)
    else $error("bus acknowledge held too long");
  a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without a request");
  a_rd_unmapped: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > FCCA_OFS_LAST
    |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_irq_off: assert property (wr_ok && avs_address_i == FCCA_OFS_MASK
    && avs_writedata_i[2:0] == 3'h0 |-> ##2 !irq_o)
    else $error("interrupt high with all sources masked");
  // payload type and stream behaviour
  a_pay_mode: assert property (wr_ok && avs_address_i == FCCA_OFS_CTRL |-> ##2
    payload_with_trailer_o == $past(avs_writedata_i[FCCA_CTRL_MODE_BIT], 2))
    else $error("payload type does not follow trailer mode");
  a_beat_next: assert property (img_ok |=> out_valid_o)
    else $error("image beat not forwarded next cycle");
  a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o
    && $stable(out_data_o) && $stable(out_last_o))
    else $error("stalled output beat changed");
  a_no_trailer: assert property (img_ok && img_last_i && !payload_with_trailer_o |=>
    out_last_o)
    else $error("trailer sent with trailer mode off");
endmodule // fcca_props

bind fcca_top fcca_props fcca_props_inst (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .img_valid_i,
  .img_last_i, .img_ready_o, .out_valid_o, .out_last_o, .out_data_o, .out_ready_i,
  .payload_with_trailer_o, .irq_o);

// ---- fcca_host.sv ----
// host model: takes image beats and trailers, stalls on request
module fcca_host
  import fcca_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // beats from the block
  input wire logic beat_valid_i,
  input wire logic beat_last_i,
  input wire logic [31:0] beat_data_i,
  input wire logic stall_i,
  output logic ready_o,
  // what was taken
  output int beats_o,
  output int frames_o,
  output logic [31:0] last_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_ff;
  // when stalling, accept only one cycle in four
  assign ready_o = !(stall_i && phase_ff != 2'h0);
  // keeps the last word of each frame, its trailer when one is appended
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff <= 2'h0;
      beats_o <= 0;
      frames_o <= 0;
      last_word_o <= 32'h0000_0000;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      if (beat_valid_i && ready_o) begin
        beats_o <= beats_o + 1;
        if (beat_last_i) begin
          frames_o <= frames_o + 1;
          last_word_o <= beat_data_i;
        end
      end
    end
  end
endmodule // fcca_host

// ---- fcca_tb.sv ----
// testbench: register, stream, clear and interrupt scenarios
module testbench
  import fcca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic frame_begin_event_i = 1'b0;
  logic frame_trigger_i = 1'b0;
  logic input_line_one_i = 1'b0;
  logic input_line_two_i = 1'b0;
  logic img_valid_i = 1'b0;
  logic img_last_i = 1'b0;
  logic [31:0] img_data_i = 32'h0000_0000;
  logic stall = 1'b0;
  logic [31:0] avs_readdata_o;
  logic [31:0] out_data_o;
  logic [31:0] rx_word;
  logic [31:0] rdat;
  logic avs_waitrequest_o;
  logic img_ready_o;
  logic out_valid_o;
  logic out_last_o;
  logic out_ready_i;
  logic payload_with_trailer_o;
  logic irq_o;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int fc = 0;
  int rx_beats;
  int rx_frames;

  // design and host model
  fcca_top fcca_top_inst (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .frame_begin_event_i, .frame_trigger_i, .input_line_one_i, .input_line_two_i,
    .img_valid_i, .img_last_i, .img_data_i, .img_ready_o, .out_valid_o, .out_last_o,
    .out_data_o, .out_ready_i, .payload_with_trailer_o, .irq_o);
  fcca_host fcca_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .beat_valid_i(out_valid_o),
    .beat_last_i(out_last_o), .beat_data_i(out_data_o), .stall_i(stall),
    .ready_o(out_ready_i), .beats_o(rx_beats), .frames_o(rx_frames), .last_word_o(rx_word));

  // 125 MHz clock
  always #4 sys_clk_i = ~sys_clk_i;

  // watchdog against hangs
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  task automatic pulse(input logic b, input logic t);
    @(posedge sys_clk_i);
    frame_begin_event_i <= b;
    frame_trigger_i <= t;
    @(posedge sys_clk_i);
    frame_begin_event_i <= 1'b0;
    frame_trigger_i <= 1'b0;
  endtask

  // raise one input line long enough to pass the synchroniser
  task automatic line(input int k);
    @(posedge sys_clk_i);
    input_line_one_i <= (k == 1);
    input_line_two_i <= (k == 2);
    repeat (4) @(posedge sys_clk_i);
    input_line_one_i <= 1'b0;
    input_line_two_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // send n beats, then check beats and last word seen by the host
  task automatic image(input int n, input logic [31:0] w, input int nb);
    int b0;
    int f0;
    b0 = rx_beats;
    f0 = rx_frames;
    @(posedge sys_clk_i);
    for (int i = 0; i < n; i++) begin
      img_valid_i <= 1'b1;
      img_last_i <= (i == n - 1);
      img_data_i <= 32'hA5A5_0000 + 32'(i);
      do @(posedge sys_clk_i); while (img_ready_o !== 1'b1);
    end
    img_valid_i <= 1'b0;
    while (rx_frames == f0) @(posedge sys_clk_i);
    chk(32'(rx_beats - b0), 32'(nb));
    chk(rx_word, w);
  endtask

  task automatic s_reset();
    rchk(FCCA_OFS_FCOUNT, 32'h0000_0000);
    rchk(FCCA_OFS_TCOUNT, 32'h0000_0001);
    rchk(FCCA_OFS_CTRL, 32'h0000_0000);
    bus(1'b0, FCCA_OFS_CLR, 32'h0000_0000);
    chk({30'h0, rdat[1:0]}, 32'h0000_0000);
    rchk(6'h20, 32'h0000_0000);
  endtask

  task automatic s_trailer();
    bus(1'b1, FCCA_OFS_CTRL, 32'h0000_0001);
    rchk(FCCA_OFS_CTRL, 32'h0000_0101);
    chk({31'h0, payload_with_trailer_o}, 32'h0000_0001);
    bus(1'b1, FCCA_OFS_CTRL, 32'h0000_0011);
    bus(1'b1, FCCA_OFS_CTRL, 32'h0000_0013);
    stall <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      pulse(1'b1, 1'b1);
      image(2, 32'(k), 3);
    end
    stall <= 1'b0;
    rchk(FCCA_OFS_FCOUNT, 32'h0000_0003);
    rchk(FCCA_OFS_LAST, 32'h0000_0002);
    rchk(FCCA_OFS_TCOUNT, 32'h0000_0004);
    pulse(1'b0, 1'b1);
    rchk(FCCA_OFS_TCOUNT, 32'h0000_0005);
    bus(1'b0, FCCA_OFS_STAT, 32'h0000_0000);
    chk({31'h0, rdat[FCCA_IRQ_FRAME]}, 32'h0000_0001);
    bus(1'b1, FCCA_OFS_MASK, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0000_0001);
    bus(1'b1, FCCA_OFS_STAT, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    bus(1'b1, FCCA_OFS_MASK, 32'h0000_0000);
    fc = 3;
  endtask

  // items forced off with trailer mode off
  task automatic s_mode_off();
    bus(1'b1, FCCA_OFS_CTRL, 32'h0000_0000);
    chk({31'h0, payload_with_trailer_o}, 32'h0000_0000);
    image(2, 32'hA5A5_0001, 2);
    bus(1'b1, FCCA_OFS_CTRL, 32'h0000_0012);
    rchk(FCCA_OFS_CTRL, 32'h0000_0010);
    bus(1'b1, FCCA_OFS_CTRL, 32'h0000_0011);
    bus(1'b0, FCCA_OFS_CTRL, 32'h0000_0000);
    chk({31'h0, rdat[FCCA_CTRL_FEN_BIT]}, 32'h0000_0000);
    image(2, 32'hA5A5_0001, 2);
  endtask

  // each clear source, foreign source ignored
  task automatic s_clear();
    bus(1'b1, FCCA_OFS_CTRL, 32'h0000_0013);
    for (int s = 1; s < 4; s++) begin
      pulse(1'b1, 1'b1);
      pulse(1'b1, 1'b1);
      fc += 2;
      bus(1'b1, FCCA_OFS_CLR, 32'h0000_0110);
      bus(1'b1, FCCA_OFS_CLR, 32'h0000_0110 | 32'(s));
      line(s == 1 ? 2 : 1);
      rchk(FCCA_OFS_FCOUNT, 32'(fc));
      if (s == 3) begin
        bus(1'b1, FCCA_OFS_CLR, 32'h0001_0113);
      end else begin
        line(s);
      end
      rchk(FCCA_OFS_FCOUNT, 32'h0000_0000);
      pulse(1'b1, 1'b1);
      image(1, 32'h0000_0000, 2);
      fc = 1;
    end
    bus(1'b1, FCCA_OFS_CLR, 32'h0000_0110);
    line(1);
    line(2);
    bus(1'b1, FCCA_OFS_CLR, 32'h0001_0110);
    rchk(FCCA_OFS_FCOUNT, 32'(fc));
  endtask

  // mid-run reset clears the count and the clear source
  task automatic s_power();
    bus(1'b1, FCCA_OFS_CLR, 32'h0000_0111);
    pulse(1'b1, 1'b1);
    rchk(FCCA_OFS_FCOUNT, 32'(fc + 1));
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rchk(FCCA_OFS_FCOUNT, 32'h0000_0000);
    rchk(FCCA_OFS_TCOUNT, 32'h0000_0001);
    bus(1'b0, FCCA_OFS_CLR, 32'h0000_0000);
    chk({30'h0, rdat[1:0]}, 32'h0000_0000);
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_trailer();
    s_mode_off();
    s_clear();
    s_power();
    print_verdict();
  end
endmodule // testbench
